// File: inc/sfr_pkg.sv
// Constants and carriers for the system interrupt enable and flag registers
package sfr_pkg;
    // Bus geometry
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;

    // Register offsets in the byte address space
    localparam logic [ADDR_W-1:0] OFS_IRQ_EN1 = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_IRQ_EN2 = 4'h1;
    localparam logic [ADDR_W-1:0] OFS_IRQ_FLG1 = 4'h2;
    localparam logic [ADDR_W-1:0] OFS_IRQ_FLG2 = 4'h3;

    // Enable register bit positions
    localparam int EN_WDT = 0;
    localparam int EN_OSC = 1;
    localparam int EN_NMI = 4;
    localparam int EN_FLASH = 5;

    // Flag register bit positions
    localparam int FLG_WDT = 0;
    localparam int FLG_OSC = 1;
    localparam int FLG_POR = 2;
    localparam int FLG_RST = 3;
    localparam int FLG_NMI = 4;

    // Bits physically present; all others read as zero
    localparam logic [DATA_W-1:0] EN_IMPL_MASK = 8'h33;
    localparam logic [DATA_W-1:0] FLG_IMPL_MASK = 8'h1F;

    // Reset values on power-on reset
    localparam logic [DATA_W-1:0] EN_POR_VAL = 8'h00;
    localparam logic [DATA_W-1:0] FLG_POR_VAL = 8'h06;

    // Bits forced by power-up clear, and the value they take
    localparam logic [DATA_W-1:0] EN_PUC_MASK = 8'h33;
    localparam logic [DATA_W-1:0] EN_PUC_VAL = 8'h00;
    localparam logic [DATA_W-1:0] FLG_PUC_MASK = 8'h12;
    localparam logic [DATA_W-1:0] FLG_PUC_VAL = 8'h02;

    // Hardware events from the watchdog, clock system, reset pin and flash
    typedef struct packed {
        logic wdt_overflow;      // Counter overflow, one-cycle pulse
        logic wdt_interval_mode; // Level: watchdog runs as interval timer
        logic key_violation;     // Wrong security key written, pulse
        logic osc_fault;         // Oscillator fault detected, level or pulse
        logic pin_reset;         // Reset seen at the reset pin in reset mode, pulse
        logic pin_nmi;           // NMI edge at the reset pin in interrupt mode, pulse
        logic flash_violation;   // Access violation flag held in the flash module
    } sfr_evt_s;
endpackage

// File: tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import sfr_pkg::*;
    logic CLK_I = 1'b0;
    logic RESET_I = 1'b1;
    logic PUC_I = 1'b0;
    logic [ADDR_W-1:0] ADDR_I = '0;
    logic [DATA_W-1:0] WDATA_I = '0;
    logic WE_I = 1'b0;
    logic RE_I = 1'b0;
    sfr_evt_s EVT_I = '0;
    logic [DATA_W-1:0] RDATA_O;
    logic WDT_IRQ_O;
    logic NMI_IRQ_O;
    logic IRQ_O;
    logic [DATA_W-1:0] rd_q[$];
    logic [2:0] irq_q[$];
    logic [6:0] evt_base = '0;
    logic re_seen = 1'b0;
    logic irq_look = 1'b0;
    int mismatches = 0;
    int samples_checked = 0;
    int cycles = 0;
    int seed = 45828;
    logic [DATA_W-1:0] rnd;
    // Addresses with no register behind them
    logic [ADDR_W-1:0] gap_addr [3] = '{4'h1, 4'h3, 4'hF};

    sfr_irq_regs DUT (.CLK_I(CLK_I), .RESET_I(RESET_I), .PUC_I(PUC_I), .ADDR_I(ADDR_I),
        .WDATA_I(WDATA_I), .WE_I(WE_I), .RE_I(RE_I), .EVT_I(EVT_I), .RDATA_O(RDATA_O),
        .WDT_IRQ_O(WDT_IRQ_O), .NMI_IRQ_O(NMI_IRQ_O), .IRQ_O(IRQ_O));

    // Free-running 100 MHz clock
    always #5 CLK_I = ~CLK_I;

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Hang guard: the whole sequence needs well under two hundred cycles
    always @(posedge CLK_I)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            mismatches++;
            end_of_test();
        end
    end

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge CLK_I);
        ADDR_I <= a;
        WDATA_I <= d;
        WE_I <= 1'b1;
        @(posedge CLK_I);
        WE_I <= 1'b0;
    endtask

    // Expectation is queued before the strobe so the monitor always finds it
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        rd_q.push_back(e);
        @(posedge CLK_I);
        ADDR_I <= a;
        RE_I <= 1'b1;
        @(posedge CLK_I);
        RE_I <= 1'b0;
    endtask

    // Two edges let a flag land and then the registered request follow it
    task automatic chk(input logic [2:0] e);
        repeat (2) @(posedge CLK_I);
        irq_q.push_back(e);
        irq_look <= 1'b1;
        @(posedge CLK_I);
        irq_look <= 1'b0;
    endtask

    // One-cycle event on top of the level inputs held in evt_base
    task automatic pulse(input int b);
        @(posedge CLK_I);
        EVT_I <= sfr_evt_s'(evt_base | (7'h01 << b));
        @(posedge CLK_I);
        EVT_I <= sfr_evt_s'(evt_base);
    endtask

    task automatic cmp_rd(input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] s);
        samples_checked++;
        if (s !== e)
        begin
            mismatches++;
            $display("FAIL RDATA_O expected %h seen %h", e, s);
        end
    endtask

    task automatic cmp_irq(input logic [2:0] e, input logic [2:0] s);
        samples_checked++;
        if (s !== e)
        begin
            mismatches++;
            $display("FAIL WDT_NMI_IRQ expected %b seen %b", e, s);
        end
    endtask

    // Monitor: read data stand only in the cycle after the strobe
    always @(posedge CLK_I)
        re_seen <= RE_I & ~RESET_I;
    always @(negedge CLK_I)
    begin
        if (re_seen)
            cmp_rd(rd_q.pop_front(), RDATA_O);
        if (irq_look)
            cmp_irq(irq_q.pop_front(), {WDT_IRQ_O, NMI_IRQ_O, IRQ_O});
    end

    initial
    begin
        repeat (4) @(posedge CLK_I);
        RESET_I <= 1'b0;
        rd(4'h0, 8'h00);
        rd(4'h2, 8'h06);
        chk(3'b000);
        wr(4'h0, 8'hFF);
        rd(4'h0, 8'h33);
        for (int i = 0; i < 3; i++)
        begin
            wr(gap_addr[i], 8'hFF);
            rd(gap_addr[i], 8'h00);
        end
        repeat (4)
        begin
            rnd = DATA_W'($random(seed));
            wr(4'h0, rnd);
            rd(4'h0, rnd & EN_IMPL_MASK);
        end
        wr(4'h2, 8'h00);
        rd(4'h2, 8'h00);
        wr(4'h0, 8'h33);
        pulse(1);
        rd(4'h2, 8'h10);
        chk(3'b011);
        wr(4'h2, 8'h00);
        chk(3'b000);
        pulse(3);
        rd(4'h2, 8'h02);
        chk(3'b011);
        wr(4'h0, 8'h31);
        chk(3'b000);
        wr(4'h2, 8'h00);
        // Flash violation is a level from the flash module
        evt_base = 7'h01;
        pulse(6);
        rd(4'h2, 8'h01);
        chk(3'b011);
        wr(4'h0, 8'h01);
        chk(3'b000);
        evt_base = 7'h20;
        pulse(5);
        chk(3'b101);
        wr(4'h2, 8'h00);
        pulse(4);
        rd(4'h2, 8'h01);
        pulse(2);
        rd(4'h2, 8'h08);
        evt_base = 7'h00;
        pulse(5);
        wr(4'h0, 8'h33);
        wr(4'h2, 8'h1F);
        @(posedge CLK_I);
        PUC_I <= 1'b1;
        @(posedge CLK_I);
        PUC_I <= 1'b0;
        rd(4'h0, 8'h00);
        rd(4'h2, 8'h0F);
        @(posedge CLK_I);
        RESET_I <= 1'b1;
        repeat (2) @(posedge CLK_I);
        RESET_I <= 1'b0;
        rd(4'h2, 8'h06);
        rd(4'h0, 8'h00);
        repeat (2) @(posedge CLK_I);
        end_of_test();
    end
endmodule

`default_nettype wire

// File: verilog/sfr_irq_regs.sv
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module sfr_irq_regs
(
    input wire logic CLK_I,
    input wire logic RESET_I,
    input wire logic PUC_I,
    input wire logic [sfr_pkg::ADDR_W-1:0] ADDR_I,
    input wire logic [sfr_pkg::DATA_W-1:0] WDATA_I,
    input wire logic WE_I,
    input wire logic RE_I,
    input wire sfr_pkg::sfr_evt_s EVT_I,
    output logic [sfr_pkg::DATA_W-1:0] RDATA_O,
    output logic WDT_IRQ_O,
    output logic NMI_IRQ_O,
    output logic IRQ_O
);
    import sfr_pkg::*;

    logic [DATA_W-1:0] en_r;
    logic [DATA_W-1:0] en_nxt;
    logic [DATA_W-1:0] flg_r;
    logic [DATA_W-1:0] flg_nxt;
    logic [DATA_W-1:0] rdata_r;
    logic [DATA_W-1:0] rdata_nxt;
    logic wdt_irq_r;
    logic wdt_irq_nxt;
    logic nmi_irq_r;
    logic nmi_irq_nxt;
    logic irq_r;
    logic irq_nxt;
    logic [DATA_W-1:0] flg_set;
    logic [DATA_W-1:0] flg_clr;

    // Hardware set and clear terms for the flag register
    always_comb
    begin
        flg_set = '0;
        flg_clr = '0;
        flg_set[FLG_WDT] = EVT_I.wdt_overflow | EVT_I.key_violation;
        flg_set[FLG_OSC] = EVT_I.osc_fault;
        flg_set[FLG_NMI] = EVT_I.pin_nmi;
        flg_set[FLG_RST] = EVT_I.pin_reset;
        flg_clr[FLG_WDT] = EVT_I.pin_reset;
    end

    // Register file next state; power-on is the synchronous reset below
    always_comb
    begin
        en_nxt = en_r;
        flg_nxt = flg_r;
        if (WE_I && ADDR_I == OFS_IRQ_EN1)
        begin
            en_nxt = WDATA_I;
        end
        // software writes zero to clear a flag
        else if (WE_I && ADDR_I == OFS_IRQ_FLG1)
        begin
            flg_nxt = WDATA_I;
        end
        // Set beats a same-cycle write or pin-reset clear; power-up clear below still drops a pin NMI
        flg_nxt = (flg_nxt & ~flg_clr) | flg_set;
        // power-up clear forces the plain-marked bits
        if (PUC_I)
        begin
            en_nxt = (en_nxt & ~EN_PUC_MASK) | EN_PUC_VAL;
            flg_nxt = (flg_nxt & ~FLG_PUC_MASK) | FLG_PUC_VAL;
        end
        // absent bits never hold a value
        en_nxt = en_nxt & EN_IMPL_MASK;
        flg_nxt = flg_nxt & FLG_IMPL_MASK;
    end

    // Read port: data stand only in the cycle after the strobe
    always_comb
    begin
        rdata_nxt = '0;
        if (RE_I)
        begin
            if (ADDR_I == OFS_IRQ_EN1)
            begin
                rdata_nxt = en_r;
            end
            else if (ADDR_I == OFS_IRQ_FLG1)
            begin
                rdata_nxt = flg_r;
            end
            // Second enable and flag bytes and unmapped addresses read zero
            else
            begin
                rdata_nxt = '0;
            end
        end
    end

    // Interrupt requests, registered so that outputs come from flops
    always_comb
    begin
        // enable only acts in interval timer mode
        wdt_irq_nxt = flg_r[FLG_WDT] & en_r[EN_WDT] & EVT_I.wdt_interval_mode;
        // own enables only, the CPU's GIE is not consulted here
        nmi_irq_nxt = (flg_r[FLG_NMI] & en_r[EN_NMI]) |
                      (flg_r[FLG_OSC] & en_r[EN_OSC]) |
                      (EVT_I.flash_violation & en_r[EN_FLASH]);
        // request only while flag and enable both set
        irq_nxt = wdt_irq_nxt | nmi_irq_nxt;
    end

    // Register file; RESET_I is the power-on reset
    always_ff @(posedge CLK_I)
    begin
        if (RESET_I)
        begin
            // bracketed bits take their value only here
            en_r <= EN_POR_VAL;
            flg_r <= FLG_POR_VAL;
        end
        else
        begin
            en_r <= en_nxt;
            flg_r <= flg_nxt;
        end
    end

    // Read data register, cleared so a stale byte never lingers
    always_ff @(posedge CLK_I)
    begin
        if (RESET_I)
        begin
            rdata_r <= '0;
        end
        else
        begin
            rdata_r <= rdata_nxt;
        end
    end

    // Request registers; one cycle of latency buys glitch-free outputs
    always_ff @(posedge CLK_I)
    begin
        if (RESET_I)
        begin
            wdt_irq_r <= 1'b0;
            nmi_irq_r <= 1'b0;
            irq_r <= 1'b0;
        end
        else
        begin
            wdt_irq_r <= wdt_irq_nxt;
            nmi_irq_r <= nmi_irq_nxt;
            irq_r <= irq_nxt;
        end
    end

    assign RDATA_O = rdata_r;
    assign WDT_IRQ_O = wdt_irq_r;
    assign NMI_IRQ_O = nmi_irq_r;
    assign IRQ_O = irq_r;

    // Checks on the register behaviour
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (RESET_I);

    // A read strobe followed by its data
    sequence s_read_en;
        RE_I && ADDR_I == OFS_IRQ_EN1;
    endsequence

    sequence s_read_flg;
        RE_I && ADDR_I == OFS_IRQ_FLG1;
    endsequence

    a_read_en_map: assert property (s_read_en |=> RDATA_O == $past(en_r))
        else $error("enable register read returned wrong data");

    a_read_flg_map: assert property (s_read_flg |=> RDATA_O == $past(flg_r))
        else $error("flag register read returned wrong data");

    a_read_idle_zero: assert property (!RE_I |=> RDATA_O == 8'h00)
        else $error("read data not zero outside the read cycle");

    a_absent_bits: assert property ((en_r & ~EN_IMPL_MASK) == 8'h00 &&
        (flg_r & ~FLG_IMPL_MASK) == 8'h00 && (RDATA_O & 8'hC0) == 8'h00)
        else $error("unimplemented bit holds a one");

    a_puc_forces: assert property (PUC_I |=> en_r == 8'h00 &&
        flg_r[FLG_OSC] && !flg_r[FLG_NMI])
        else $error("power-up clear did not force plain-marked bits");

    a_puc_keeps_por: assert property (PUC_I && !WE_I && flg_set == 8'h00 &&
        flg_clr == 8'h00 |=> (flg_r & 8'h0D) == $past(flg_r & 8'h0D))
        else $error("power-up clear disturbed a power-on-only bit");

    a_por_values: assert property ($past(RESET_I) |-> flg_r == 8'h06 &&
        en_r == 8'h00 && !IRQ_O)
        else $error("power-on values wrong after reset release");

    a_wdt_mode_gate: assert property (!EVT_I.wdt_interval_mode |=> !WDT_IRQ_O)
        else $error("watchdog interrupt raised in watchdog mode");

    a_wdt_flag_set: assert property (EVT_I.wdt_overflow || EVT_I.key_violation
        |=> flg_r[FLG_WDT])
        else $error("watchdog flag not set by its event");

    a_pin_reset_flags: assert property (EVT_I.pin_reset && !flg_set[FLG_WDT]
        |=> !flg_r[FLG_WDT] && flg_r[FLG_RST])
        else $error("pin reset did not update watchdog and reset flags");

    // A pin NMI event that no power-up clear overrides
    sequence s_nmi_event;
        EVT_I.pin_nmi && !PUC_I;
    endsequence

    // Flag lands one edge after the event, request one edge later
    sequence s_nmi_armed;
        s_nmi_event ##1 en_r[EN_NMI];
    endsequence

    a_nmi_flag_set: assert property (s_nmi_event |=> flg_r[FLG_NMI])
        else $error("pin NMI flag not set by its event");

    a_nmi_request: assert property (s_nmi_armed |=> NMI_IRQ_O)
        else $error("pin NMI request not raised after its flag");

    a_zero_clears: assert property (WE_I && ADDR_I == OFS_IRQ_FLG1 &&
        !WDATA_I[FLG_POR] |=> !flg_r[FLG_POR])
        else $error("writing zero did not clear the flag");

    a_irq_pairs: assert property (IRQ_O == (WDT_IRQ_O || NMI_IRQ_O) &&
        (IRQ_O -> $past(|(flg_r & en_r) | (EVT_I.flash_violation & en_r[EN_FLASH]))))
        else $error("request without matching flag and enable");

    a_nmi_own_en: assert property (flg_r[FLG_OSC] && en_r[EN_OSC]
        |=> NMI_IRQ_O && IRQ_O)
        else $error("oscillator fault request not raised by its enable");

    // Software write paths, taken only when no clear or event interferes
    sequence s_en_write;
        WE_I && ADDR_I == OFS_IRQ_EN1 && !PUC_I;
    endsequence

    sequence s_flg_write;
        WE_I && ADDR_I == OFS_IRQ_FLG1 && !PUC_I && flg_set == 8'h00 && flg_clr == 8'h00;
    endsequence

    a_en_write: assert property (s_en_write |=> en_r == ($past(WDATA_I) & EN_IMPL_MASK))
        else $error("enable register write did not land");

    a_en_hold: assert property (!(WE_I && ADDR_I == OFS_IRQ_EN1) && !PUC_I |=> $stable(en_r))
        else $error("enable register changed without a write");

    a_flg_write: assert property (s_flg_write |=> flg_r == ($past(WDATA_I) & FLG_IMPL_MASK))
        else $error("flag register write did not land");

    a_read_gap_zero: assert property (RE_I && ADDR_I != OFS_IRQ_EN1 &&
        ADDR_I != OFS_IRQ_FLG1 |=> RDATA_O == 8'h00)
        else $error("empty address read returned data");

    // Flags raised by their own cause; power-on and reset flags by no other but a write
    a_osc_flag_set: assert property (EVT_I.osc_fault |=> flg_r[FLG_OSC])
        else $error("oscillator fault flag not set by its event");

    a_por_flag_only: assert property (!flg_r[FLG_POR] &&
        !(WE_I && ADDR_I == OFS_IRQ_FLG1 && WDATA_I[FLG_POR]) |=> !flg_r[FLG_POR])
        else $error("power-on flag rose without a power-on");

    a_rst_flag_only: assert property (!flg_r[FLG_RST] && !EVT_I.pin_reset &&
        !(WE_I && ADDR_I == OFS_IRQ_FLG1 && WDATA_I[FLG_RST]) |=> !flg_r[FLG_RST])
        else $error("external reset flag rose without a pin reset");

    // Request paths: each source raises its line, nothing else does
    a_wdt_request: assert property (flg_r[FLG_WDT] && en_r[EN_WDT] &&
        EVT_I.wdt_interval_mode |=> WDT_IRQ_O)
        else $error("interval watchdog request not raised");

    a_flash_request: assert property (EVT_I.flash_violation && en_r[EN_FLASH] |=> NMI_IRQ_O)
        else $error("flash violation request not raised");

    a_nmi_blocked: assert property (!en_r[EN_NMI] && !en_r[EN_OSC] && !en_r[EN_FLASH]
        |=> !NMI_IRQ_O)
        else $error("non-maskable request raised with its enables off");

    a_no_cause_idle: assert property ((flg_r & en_r & 8'h13) == 8'h00 &&
        !(EVT_I.flash_violation && en_r[EN_FLASH]) |=> !IRQ_O)
        else $error("request raised without a flag and enable pair");
endmodule

`default_nettype wire
